// ### rtl/flash_ctrl_dev.sv
// Flash control end: control register, timed windows, lock and fuse reads,
// application-section read block and timed flash writes.
// Assumes the flash array sits on the user side and reads back in one cycle.
`timescale 1ns/1ps
module flash_ctrl_dev
    import spm_pkg::*;
#(
    parameter int         PROG_CYCLES = PROG_MIN_CYC,
    parameter logic [7:0] FUSE_LO     = 8'hff,
    parameter logic [7:0] FUSE_HI     = 8'hff,
    parameter logic [7:0] FUSE_EXT    = 8'hff
) (
    input  wire logic        clk_i,               // Core clock
    input  wire logic        rst_i,               // System reset, active high
    input  wire logic        por_i,               // Power-on reset, active high
    input  wire logic        eeprom_write_busy_i, // EEPROM write in progress
    input  wire logic [7:0]  flash_rd_data_i,     // Flash byte at read address
    output logic      [16:0] flash_rd_addr_o,     // Flash byte read address
    output logic             flash_erase_o,       // Page erase start pulse
    output logic             flash_write_o,       // Page write start pulse
    output logic      [8:0]  flash_page_o,        // Latched page number
    output logic             buf_load_o,          // Page buffer word load pulse
    output logic      [6:0]  buf_word_o,          // Page buffer word index
    output logic      [15:0] buf_data_o,          // Page buffer word data
    output logic             buf_clear_o,         // Page buffer erase pulse
    output logic      [7:0]  lock_bits_o,         // Current lock byte
    spm_if.dev               bus                  // Core link
);
    typedef struct packed {
        logic [7:0]  ctrl;
        logic        busy;
        logic        halt;
        logic [2:0]  win;
        op_t         op;
        logic [8:0]  page;
        logic [7:0]  lock_bits;
        logic [7:0]  lock_new;
        logic        rd_pend;
        logic        rd_cfg;
        logic        rd_blk;
        logic [7:0]  cfg_val;
        logic [16:0] rd_addr;
        logic [7:0]  lpm_data;
        logic        lpm_valid;
        logic        erase_go;
        logic        write_go;
        logic        load_go;
        logic        clear_go;
        logic [6:0]  word;
        logic [15:0] wdata;
        logic        ee_busy;
        logic        ee_sync;
    } dev_state_t;

    localparam dev_state_t S_RESET = '{
        ctrl: CTRL_RESET, busy: 1'b0, halt: 1'b0, win: '0, op: OP_IDLE,
        page: '0, lock_bits: LOCK_RESET, lock_new: LOCK_RESET,
        rd_pend: 1'b0, rd_cfg: 1'b0, rd_blk: 1'b0, cfg_val: '0, rd_addr: '0,
        lpm_data: '0, lpm_valid: 1'b0, erase_go: 1'b0, write_go: 1'b0,
        load_go: 1'b0, clear_go: 1'b0, word: '0, wdata: '0,
        ee_busy: 1'b0, ee_sync: 1'b0
    };

    dev_state_t s;
    dev_state_t next_s;
    logic       op_done;
    logic       tmr_start;
    logic       idle;
    logic       spm_ok;
    logic       cfg_ok;
    logic       app_addr;

    // Write timer, cleared only by power-on
    prog_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clk_i   (clk_i),
        .por_i   (por_i),
        .start_i (tmr_start),
        .done_o  (op_done)
    );

    // ======================================================================
    // Window and command qualifiers
    assign idle     = (s.op == OP_IDLE);
    assign spm_ok   = s.ctrl[BIT_SE] && idle && (s.win < SPM_WINDOW) && !s.ee_busy;
    assign cfg_ok   = s.ctrl[BIT_SE] && s.ctrl[BIT_LOCK] && idle
                      && (s.win < LPM_WINDOW) && !s.ee_busy;
    assign app_addr = (bus.z_addr[16:8] < APP_END_PAGE);

    // ======================================================================
    // Next-state logic
    always_comb begin
        next_s           = s;
        next_s.ee_sync   = eeprom_write_busy_i;
        next_s.ee_busy   = s.ee_sync;
        next_s.lpm_valid = 1'b0;
        next_s.rd_pend   = 1'b0;
        next_s.erase_go  = 1'b0;
        next_s.write_go  = 1'b0;
        next_s.load_go   = 1'b0;
        next_s.clear_go  = 1'b0;

        // Open window expires after its last cycle
        if (s.ctrl[BIT_SE] && idle) begin
            next_s.win = s.win + 3'h1;
            if (s.win == SPM_WINDOW - 3'h1) begin
                next_s.ctrl = s.ctrl & (8'h1 << BIT_IE);
            end
        end

        // Control write is refused while the EEPROM or flash is busy
        if (bus.ctrl_wr && idle && !s.ee_busy) begin
            next_s.win  = '0;
            next_s.ctrl = bus.ctrl_wdata[BIT_SE] ? (bus.ctrl_wdata & CTRL_WR_MASK)
                                                 : (bus.ctrl_wdata & (8'h1 << BIT_IE));
        end

        // Store instruction inside the window
        if (bus.spm_exec && spm_ok) begin
            next_s.ctrl = s.ctrl & (8'h1 << BIT_IE);
            case (s.ctrl[4:0])
                CMD_LOAD: begin
                    next_s.load_go = 1'b1;
                    next_s.word    = bus.z_addr[7:1];
                    next_s.wdata   = {bus.high_data, bus.low_data};
                    next_s.busy    = 1'b0;
                end
                CMD_ERASE: begin
                    next_s.ctrl     = s.ctrl;
                    next_s.op       = OP_ERASE;
                    next_s.page     = bus.z_addr[16:8];
                    next_s.erase_go = 1'b1;
                    next_s.busy     = s.busy | app_addr;
                    next_s.halt     = !app_addr;
                end
                CMD_WRITE: begin
                    next_s.ctrl     = s.ctrl;
                    next_s.op       = OP_WRITE;
                    next_s.page     = bus.z_addr[16:8];
                    next_s.write_go = 1'b1;
                    next_s.busy     = s.busy | app_addr;
                    next_s.halt     = !app_addr;
                end
                CMD_LOCK: begin
                    next_s.ctrl     = s.ctrl;
                    next_s.op       = OP_LOCK;
                    next_s.lock_new = bus.low_data | ~LOCK_DATA_MASK;
                end
                CMD_RE: begin
                    next_s.busy     = 1'b0;
                    next_s.clear_go = 1'b1;
                end
                default: begin
                    next_s.ctrl = s.ctrl & (8'h1 << BIT_IE);
                end
            endcase
        end

        // Load instruction: configuration byte or flash byte
        if (bus.lpm_exec) begin
            next_s.rd_pend = 1'b1;
            next_s.rd_addr = bus.z_addr;
            next_s.rd_cfg  = cfg_ok;
            next_s.rd_blk  = !cfg_ok && s.busy && app_addr;
            if (bus.z_addr[15:0] == Z_LOCK) begin
                next_s.cfg_val = s.lock_bits;
            end else if (bus.z_addr[15:0] == Z_FUSE_LO) begin
                next_s.cfg_val = FUSE_LO;
            end else if (bus.z_addr[15:0] == Z_FUSE_HI) begin
                next_s.cfg_val = FUSE_HI;
            end else if (bus.z_addr[15:0] == Z_FUSE_EXT) begin
                next_s.cfg_val = FUSE_EXT;
            end else begin
                next_s.cfg_val = BLOCKED_DATA;
            end
            if (cfg_ok) begin
                next_s.ctrl = s.ctrl & (8'h1 << BIT_IE);
            end
        end

        // Answer one cycle after the flash address was presented
        if (s.rd_pend) begin
            next_s.lpm_valid = 1'b1;
            next_s.lpm_data  = s.rd_cfg ? s.cfg_val
                             : (s.rd_blk ? BLOCKED_DATA : flash_rd_data_i);
        end

        // Timed write completes; busy flag stays until read-enable or a buffer load
        if (op_done && !idle) begin
            if (s.op == OP_LOCK) begin
                next_s.lock_bits = s.lock_bits & s.lock_new;
            end
            if (s.op == OP_WRITE) begin
                next_s.clear_go = 1'b1;
            end
            next_s.op   = OP_IDLE;
            next_s.halt = 1'b0;
            next_s.ctrl = s.ctrl & (8'h1 << BIT_IE);
        end

        // System reset keeps a running write and its results
        if (rst_i) begin
            next_s           = S_RESET;
            next_s.op        = (op_done && !idle) ? OP_IDLE : s.op;
            next_s.halt      = (op_done && !idle) ? 1'b0 : s.halt;
            next_s.ctrl      = (op_done || idle) ? CTRL_RESET : (s.ctrl & ~(8'h1 << BIT_IE));
            next_s.busy      = s.busy;
            next_s.page      = s.page;
            next_s.lock_new  = s.lock_new;
            next_s.lock_bits = (op_done && s.op == OP_LOCK) ? (s.lock_bits & s.lock_new)
                                                             : s.lock_bits;
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_i) begin
            s <= S_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Timer starts on the cycle a write is accepted
    assign tmr_start = idle && (next_s.op != OP_IDLE);

    // ======================================================================
    // Outputs
    assign bus.ctrl_rdata  = {s.ctrl[BIT_IE], s.busy, 1'b0, s.ctrl[4:0]};
    assign bus.lpm_data    = s.lpm_data;
    assign bus.lpm_valid   = s.lpm_valid;
    assign bus.app_blocked = s.busy;
    assign bus.cpu_halt    = s.halt;
    assign bus.ee_busy     = s.ee_busy;
    assign flash_rd_addr_o = s.rd_addr;
    assign flash_erase_o   = s.erase_go;
    assign flash_write_o   = s.write_go;
    assign flash_page_o    = s.page;
    assign buf_load_o      = s.load_go;
    assign buf_word_o      = s.word;
    assign buf_data_o      = s.wdata;
    assign buf_clear_o     = s.clear_go;
    assign lock_bits_o     = s.lock_bits;
endmodule : flash_ctrl_dev

// ### rtl/spm_pkg.sv
// Constants, op states and field layout for the self-programming flash control.
// Assumes one 40 MHz core clock shared by the core end and the flash end.
package spm_pkg;
    // ======================================================================
    // Timing
    localparam int CLK_KHZ      = 40000;
    localparam int PROG_MIN_US  = 3700;  // 3.7 ms
    localparam int PROG_MAX_US  = 4500;  // 4.5 ms
    localparam int PROG_MIN_CYC = (PROG_MIN_US * CLK_KHZ + 999) / 1000;
    localparam int PROG_MAX_CYC = (PROG_MAX_US * CLK_KHZ) / 1000;
    localparam int TMR_W        = 18;
    localparam logic [2:0] SPM_WINDOW = 3'h4;
    localparam logic [2:0] LPM_WINDOW = 3'h3;

    // ======================================================================
    // Control register bit positions
    localparam int BIT_IE   = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_RE   = 4;
    localparam int BIT_LOCK = 3;
    localparam int BIT_PGWR = 2;
    localparam int BIT_PGER = 1;
    localparam int BIT_SE   = 0;
    localparam logic [7:0] CTRL_WR_MASK = 8'h9f;
    localparam logic [7:0] CTRL_RESET   = 8'h00;

    // Command patterns on bits 4:0
    localparam logic [4:0] CMD_LOAD  = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK  = 5'h09;
    localparam logic [4:0] CMD_RE    = 5'h11;

    // ======================================================================
    // Lock, fuse and address layout
    localparam logic [7:0]  LOCK_DATA_MASK = 8'h3c;
    localparam logic [7:0]  LOCK_RESET     = 8'hff;
    localparam logic [7:0]  BLOCKED_DATA   = 8'hff;
    localparam logic [15:0] Z_FUSE_LO      = 16'h0000;
    localparam logic [15:0] Z_LOCK         = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT     = 16'h0002;
    localparam logic [15:0] Z_FUSE_HI      = 16'h0003;
    localparam logic [8:0]  APP_END_PAGE   = 9'h1e0;

    // ======================================================================
    // Core-end register map (byte offsets) and fields
    localparam logic [7:0] HOST_CMD  = 8'h00;
    localparam logic [7:0] HOST_Z    = 8'h04;
    localparam logic [7:0] HOST_DATA = 8'h08;
    localparam logic [7:0] HOST_STAT = 8'h0c;
    localparam int CMD_DO_SPM = 8;
    localparam int CMD_DO_LPM = 9;

    typedef enum logic [3:0] {
        OP_IDLE  = 4'b0001,
        OP_ERASE = 4'b0010,
        OP_WRITE = 4'b0100,
        OP_LOCK  = 4'b1000
    } op_t;

    typedef enum logic [3:0] {
        SQ_IDLE = 4'b0001,
        SQ_CTRL = 4'b0010,
        SQ_EXEC = 4'b0100,
        SQ_WAIT = 4'b1000
    } seq_t;
endpackage : spm_pkg

// ### rtl/spm_if.sv
// Link between the processor core end and the flash control end.
// Assumes both ends run on the same clock; the bench joins them.
`timescale 1ns/1ps
interface spm_if;
    logic        ctrl_wr;     // Control register write strobe
    logic [7:0]  ctrl_wdata;  // Control register write value
    logic [7:0]  ctrl_rdata;  // Control register read value
    logic        spm_exec;    // Store instruction pulse
    logic        lpm_exec;    // Load instruction pulse
    logic [16:0] z_addr;      // Byte pointer with upper page select
    logic [7:0]  low_data;    // Low data register
    logic [7:0]  high_data;   // High data register
    logic [7:0]  lpm_data;    // Load result
    logic        lpm_valid;   // Load result strobe
    logic        app_blocked; // Application section read block
    logic        cpu_halt;    // Core halted during halting-section write
    logic        ee_busy;     // EEPROM write in progress

    modport dev (input ctrl_wr, ctrl_wdata, spm_exec, lpm_exec, z_addr, low_data, high_data,
                 output ctrl_rdata, lpm_data, lpm_valid, app_blocked, cpu_halt, ee_busy);
    modport core (output ctrl_wr, ctrl_wdata, spm_exec, lpm_exec, z_addr, low_data, high_data,
                  input ctrl_rdata, lpm_data, lpm_valid, app_blocked, cpu_halt, ee_busy);
endinterface : spm_if

// ### rtl/prog_timer.sv
// Down counter that times one flash write from its start pulse.
// Assumes it is cleared only by power-on, so a write survives system reset.
`timescale 1ns/1ps
module prog_timer
    import spm_pkg::*;
#(
    parameter int CYCLES = PROG_MIN_CYC
) (
    input  wire logic clk_i,   // Core clock
    input  wire logic por_i,   // Power-on reset, active high
    input  wire logic start_i, // Start pulse
    output logic      done_o   // Last cycle of the write
);
    localparam logic [TMR_W-1:0] LOAD = TMR_W'(CYCLES);
    localparam logic [TMR_W-1:0] ONE  = TMR_W'(1);

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } tmr_state_t;

    tmr_state_t s;
    tmr_state_t next_s;

    // Count down while a write runs
    always_comb begin
        next_s = s;
        if (start_i) begin
            next_s.cnt = LOAD;
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - ONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done_o = (s.cnt == ONE);
endmodule : prog_timer

// ### rtl/flash_core_end.sv
// Core end: takes orders over classic Wishbone and plays the timed
// control-write then store or load sequence on the link.
// Assumes a single Wishbone master and the same clock as the flash end.
`timescale 1ns/1ps
module flash_core_end
    import spm_pkg::*;
(
    input  wire logic        clk_i,    // Core clock
    input  wire logic        rst_i,    // Synchronous reset, active high
    input  wire logic [7:0]  wb_adr_i, // Byte address
    input  wire logic [31:0] wb_dat_i, // Write data
    input  wire logic [3:0]  wb_sel_i, // Byte selects
    input  wire logic        wb_we_i,  // Write enable
    input  wire logic        wb_cyc_i, // Cycle
    input  wire logic        wb_stb_i, // Strobe
    output logic      [31:0] wb_dat_o, // Read data
    output logic             wb_ack_o, // Acknowledge
    spm_if.core              bus       // Flash link
);
    typedef struct packed {
        seq_t        seq;
        logic [9:0]  cmd;
        logic [16:0] z;
        logic [15:0] data;
        logic [7:0]  result;
        logic        done;
        logic        ack;
        logic [31:0] rdat;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;
    logic [31:0] bmask;
    logic        wr_hit;

    // Byte-select expansion
    for (genvar i = 0; i < 4; i++) begin : g_mask
        assign bmask[8*i +: 8] = {8{wb_sel_i[i]}};
    end

    assign wr_hit = wb_cyc_i && wb_stb_i && s.ack && wb_we_i;

    // ======================================================================
    // Bus slave and sequencer
    always_comb begin
        next_s     = s;
        next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
        if (wb_adr_i == HOST_CMD) begin
            next_s.rdat = {22'h0, s.cmd};
        end else if (wb_adr_i == HOST_Z) begin
            next_s.rdat = {15'h0, s.z};
        end else if (wb_adr_i == HOST_DATA) begin
            next_s.rdat = {16'h0, s.data};
        end else if (wb_adr_i == HOST_STAT) begin
            next_s.rdat = {14'h0, s.done, (s.seq != SQ_IDLE), s.result, bus.ctrl_rdata};
        end else begin
            next_s.rdat = 32'h0;
        end

        // Writes take effect on the edge that the master sees ack
        if (wr_hit && wb_adr_i == HOST_CMD && s.seq == SQ_IDLE) begin
            next_s.cmd  = wb_dat_i[9:0];
            next_s.done = 1'b0;
            next_s.seq  = SQ_CTRL;
        end else if (wr_hit && wb_adr_i == HOST_Z) begin
            next_s.z = (s.z & ~bmask[16:0]) | (wb_dat_i[16:0] & bmask[16:0]);
        end else if (wr_hit && wb_adr_i == HOST_DATA) begin
            next_s.data = (s.data & ~bmask[15:0]) | (wb_dat_i[15:0] & bmask[15:0]);
        end

        case (s.seq)
            SQ_CTRL: begin
                // Wait for store-enable clear and no EEPROM write
                if (!bus.ctrl_rdata[BIT_SE] && !bus.ee_busy) begin
                    next_s.seq = (s.cmd[CMD_DO_SPM] || s.cmd[CMD_DO_LPM]) ? SQ_EXEC : SQ_IDLE;
                end
            end
            SQ_EXEC: begin
                next_s.seq = s.cmd[CMD_DO_LPM] ? SQ_WAIT : SQ_IDLE;
            end
            SQ_WAIT: begin
                if (bus.lpm_valid) begin
                    next_s.result = bus.lpm_data;
                    next_s.done   = 1'b1;
                    next_s.seq    = SQ_IDLE;
                end
            end
            default: begin
                next_s.seq = next_s.seq;
            end
        endcase

        if (rst_i) begin
            next_s = '{seq: SQ_IDLE, default: '0};
        end
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    // ======================================================================
    // Link and bus outputs
    assign bus.ctrl_wr    = (s.seq == SQ_CTRL) && !bus.ctrl_rdata[BIT_SE]
                            && !bus.ee_busy;
    assign bus.ctrl_wdata = s.cmd[7:0];
    assign bus.spm_exec   = (s.seq == SQ_EXEC) && s.cmd[CMD_DO_SPM];
    assign bus.lpm_exec   = (s.seq == SQ_EXEC) && s.cmd[CMD_DO_LPM];
    assign bus.z_addr     = s.z;
    assign bus.low_data   = s.data[7:0];
    assign bus.high_data  = s.data[15:8];
    assign wb_dat_o       = s.rdat;
    assign wb_ack_o       = s.ack;
endmodule : flash_core_end

// ### test/spm_checker.sv
// Checker on the link between the core end and the flash end.
// Assumes one clock; the bench places it beside the link.
`timescale 1ns/1ps
module spm_checker
    import spm_pkg::*;
#(
    parameter logic [7:0] FUSE_LO = 8'hff
) (
    input  wire logic        clk_i,       // Core clock
    input  wire logic        rst_i,       // Reset
    input  wire logic        spm_exec,    // Store pulse
    input  wire logic        lpm_exec,    // Load pulse
    input  wire logic [16:0] z_addr,      // Pointer
    input  wire logic [7:0]  ctrl_rdata,  // Control value
    input  wire logic [7:0]  lpm_data,    // Load result
    input  wire logic        lpm_valid,   // Load strobe
    input  wire logic        app_blocked, // Read block
    input  wire logic        ee_busy      // EEPROM busy
);
    // ======================================================================
    // Link properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire cfg = ctrl_rdata[3:0] == 4'h9;
    wire app = z_addr[16:8] < APP_END_PAGE;
    property p_flag; app_blocked == ctrl_rdata[BIT_BUSY]; endproperty
    a_flag: assert property (p_flag) else $error("busy flag and block differ");
    property p_blk; lpm_exec && app_blocked && !cfg && app |-> ##2 lpm_data == 8'hff; endproperty
    a_blk: assert property (p_blk) else $error("blocked read returned data");
    property p_lpm; lpm_exec |-> ##2 lpm_valid; endproperty
    a_lpm: assert property (p_lpm) else $error("load result late");
    property p_fuse; lpm_exec && cfg && !ee_busy && z_addr[15:0] == 16'h0 |-> ##2 lpm_data == FUSE_LO;
    endproperty
    a_fuse: assert property (p_fuse) else $error("low fuse wrong");
    property p_tmo; $rose(ctrl_rdata[0]) ##0 !(spm_exec || lpm_exec) [*5] |=> !ctrl_rdata[0];
    endproperty
    a_tmo: assert property (p_tmo) else $error("window did not close");
    property p_ee; $past(ee_busy) |-> !$rose(ctrl_rdata[0]); endproperty
    a_ee: assert property (p_ee) else $error("control taken during EEPROM write");
    // An erase store to an application page with no EEPROM write must set the read block next cycle
    property p_ers; spm_exec && ctrl_rdata[4:0] == CMD_ERASE && app && !ee_busy |=> app_blocked;
    endproperty
    a_ers: assert property (p_ers) else $error("erase did not block");
    property p_hold; app_blocked && ctrl_rdata[2:1] != 2'h0 |=> app_blocked; endproperty
    a_hold: assert property (p_hold) else $error("block dropped during op");
    c_ers: cover property (spm_exec && ctrl_rdata[4:0] == CMD_ERASE);
    c_lock: cover property (lpm_exec && cfg && z_addr[15:0] == 16'h1);
    c_tmo: cover property ($fell(ctrl_rdata[0]) && !app_blocked);
endmodule : spm_checker

// ### test/self_program_flash_control_bench.sv
// Bench: core end and flash end joined by the link, driven over Wishbone.
// Assumes a 40 MHz clock and a shortened write count.
`timescale 1ns/1ps
module self_program_flash_control_bench;
    import spm_pkg::*;
    logic        clk_i = 0, rst_i = 1, por_i = 1, ee = 0, cyc = 0, we = 0, ack;
    logic        bl, fw;
    logic [3:0]  sel = 0;
    logic [6:0]  lw, bw;
    logic [15:0] wd, ld, bd;
    logic [7:0]  adr = 0, rdf, d, lk = 8'hff, lo;
    logic [7:0]  fx[4] = '{8'he1, 8'hff, 8'hfd, 8'h99};
    logic [8:0]  pg, wp, fp;
    logic [16:0] fa;
    logic [31:0] wdat = 0, rdat, st;
    int          n_fail = 0, tests_run = 0, cyc_n = 0;
    spm_if link ();
    flash_core_end i_flash_core_end (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_dat_o(rdat), .wb_ack_o(ack), .bus(link.core));
    flash_ctrl_dev #(.PROG_CYCLES(20), .FUSE_LO(8'he1), .FUSE_HI(8'h99), .FUSE_EXT(8'hfd))
    i_flash_ctrl_dev (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .eeprom_write_busy_i(ee),
        .flash_rd_data_i(rdf), .flash_rd_addr_o(fa), .flash_erase_o(), .flash_write_o(fw),
        .flash_page_o(fp), .buf_load_o(bl), .buf_word_o(bw), .buf_data_o(bd), .buf_clear_o(),
        .lock_bits_o(lo), .bus(link.dev));
    spm_checker #(.FUSE_LO(8'he1)) i_spm_checker (.clk_i(clk_i), .rst_i(rst_i),
        .spm_exec(link.spm_exec), .lpm_exec(link.lpm_exec), .z_addr(link.z_addr),
        .ctrl_rdata(link.ctrl_rdata), .lpm_data(link.lpm_data), .lpm_valid(link.lpm_valid),
        .app_blocked(link.app_blocked), .ee_busy(link.ee_busy));
    // Flash array answers in the same cycle
    assign rdf = fa[7:0] ^ 8'h5c;
    // Catch the buffer load and page write pulses of the flash end
    always @(posedge clk_i) begin
        if (bl) {lw, ld} <= {bw, bd};
        if (fw) wp <= fp;
    end
    always #12.5 clk_i = ~clk_i;
    // Cut a hang short
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        @(posedge clk_i);
        cyc <= 1;
        we <= w;
        adr <= a;
        wdat <= dt;
        sel <= 4'hf;
        do @(posedge clk_i); while (ack !== 1'b1);
        st = rdat;
        cyc <= 0;
        @(posedge clk_i);
    endtask : wb
    task automatic cmd(input logic [16:0] z, input logic [9:0] c);
        wb(1, HOST_Z, 32'(z));
        do wb(0, HOST_STAT, 0); while (st[16] | st[0]);
        wb(1, HOST_CMD, 32'(c));
    endtask : cmd
    task automatic fin(input logic [7:0] exp);
        do wb(0, HOST_STAT, 0); while (st[17] !== 1'b1);
        chk(st[15:8], exp);
    endtask : fin
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    initial begin
        d = 8'($urandom(32'hfc07)) | 8'hc3;
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        por_i <= 0;
        for (int i = 0; i < 4; i++) begin
            cmd(17'(i), 10'h209);
            fin(fx[i]);
        end
        $display("test done: config reads");
        wb(1, HOST_DATA, {24'h0, d});
        cmd(17'h1, 10'h109);
        wb(0, HOST_STAT, 0);
        chk(8'(st[6]), 8'h0);
        lk = lk & (d | ~8'h3c);
        cmd(17'h1, 10'h209);
        fin(lk);
        chk(lo, lk);
        $display("test done: lock write");
        pg = 9'($urandom % 480);
        cmd({pg, 8'h0}, 10'h103);
        // Let the store be taken so that the reset meets a running erase
        repeat (2) @(posedge clk_i);
        rst_i <= 1;
        @(posedge clk_i);
        rst_i <= 0;
        wb(0, HOST_STAT, 0);
        chk(st[7:0] & 8'h43, 8'h43);
        cmd({pg, 8'h10}, 10'h200);
        fin(8'hff);
        cmd(17'h0, 10'h111);
        cmd({pg, 8'h10}, 10'h200);
        fin(8'h4c);
        $display("test done: erase and block");
        wd = 16'($urandom);
        wb(1, HOST_DATA, 32'(wd));
        cmd({pg, 8'h0}, 10'h103);
        cmd({pg, 8'h12}, 10'h101);
        wb(0, HOST_STAT, 0);
        chk(8'(st[6]), 8'h0);
        chk(8'(lw), 8'h09);
        chk(ld[7:0], wd[7:0]);
        chk(ld[15:8], wd[15:8]);
        cmd({pg, 8'h0}, 10'h105);
        wb(0, HOST_STAT, 0);
        chk(st[7:0], 8'h45);
        chk(wp[7:0], pg[7:0]);
        chk(8'(wp[8]), 8'(pg[8]));
        cmd(17'h0, 10'h111);
        $display("test done: page load and write");
        cmd(17'h0, 10'h009);
        repeat (8) @(posedge clk_i);
        wb(0, HOST_STAT, 0);
        chk(8'(st[0]), 8'h0);
        cmd(17'h0, 10'h200);
        fin(8'h5c);
        ee <= 1;
        cmd(17'h0, 10'h209);
        repeat (10) @(posedge clk_i);
        wb(0, HOST_STAT, 0);
        chk(8'(st[0]), 8'h0);
        ee <= 0;
        fin(8'he1);
        $display("test done: timeout and eeprom");
        end_sim();
    end
endmodule : self_program_flash_control_bench
